// file: src/charge_level_warning_flags_regs.vh
/*
 Register map, field positions, reset values and counts for the
 charge level warning block. Assumes a 32-bit AXI4-Lite slave bus.
*/
`ifndef CHARGE_LEVEL_WARNING_FLAGS_REGS_VH
`define CHARGE_LEVEL_WARNING_FLAGS_REGS_VH

// ----------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------
`define ADDR_CTRL       8'h00
`define ADDR_INIT_SET   8'h04
`define ADDR_INIT_CLR   8'h08
`define ADDR_FINAL_SET  8'h0c
`define ADDR_FINAL_CLR  8'h10
`define ADDR_DSG_THR    8'h14
`define ADDR_EFF        8'h18
`define ADDR_CAPACITY   8'h1c
`define ADDR_FLAGS      8'h20
`define ADDR_REPORTED   8'h24
`define ADDR_INT_STS    8'h28
`define ADDR_INT_MASK   8'h2c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_HOLD_BIT   0
`define CTRL_EFF_LO     1
`define CTRL_EFF_HI     2
`define FLAG_INIT_BIT   0
`define FLAG_FINAL_BIT  1
`define FLAG_DSG_BIT    2
`define EV_W            3
`define EFF_SHIFT       8

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define RST_CTRL        3'h0
`define RST_INIT_SET    16'h0064
`define RST_INIT_CLR    16'h0096
`define RST_FINAL_SET   16'h0032
`define RST_FINAL_CLR   16'h0064
`define RST_DSG_THR     16'h003c
`define RST_EFF         32'hffffffff
`define RST_CAPACITY    16'h03e8
`define FINAL_DISABLED  16'hffff
`define SAMPLES_PER_MAH 32'h00000e10
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// file: src/charge_level_warning_flags.v
/*
 Coulomb counting remaining capacity with two low charge warning
 flags, an optional rise hold on the reported value and an AXI4-Lite
 register slave with a level interrupt.
 Assumes signed sense samples in mA from an ADC on i_sys_clk, one
 valid pulse per sample, and a synchronous active high reset.
*/
// The placing of the registers and the AXI4-Lite slave port were decided locally.
// Function
// - Integrate sensed current into remaining capacity
// - Set initial flag below its set level
// - Clear initial flag above its clear level
// - Set final flag below its set level
// - Final set level minus one disables setting
// - Clear final flag only when set, above clear
// - Hold stops reported value rising in discharge
// - Scale charge by one of four factors
// - Discharge only beyond discharge current threshold
`timescale 1ns/1ps
`include "charge_level_warning_flags_regs.vh"

module charge_level_warning_flags (
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rst,
  // Sense samples
  input  wire [15:0] i_sense_input_positive,
  input  wire [15:0] i_sense_input_negative,
  input  wire        i_sense_valid,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // Status outputs
  output wire        o_initial_low_charge_flag,
  output wire        o_final_low_charge_flag,
  output wire [15:0] o_reported_capacity,
  output wire        o_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [2:0]  ctrl_q;       // Hold option and efficiency select
  reg  [15:0] init_set_q;   // Initial warning set level
  reg  [15:0] init_clr_q;   // Initial warning clear level
  reg  [15:0] final_set_q;  // Final warning set level
  reg  [15:0] final_clr_q;  // Final warning clear level
  reg  [15:0] dsg_thr_q;    // Discharge current threshold
  reg  [31:0] eff_q;        // Four efficiency factors, one per byte
  reg  [15:0] cap_q;        // Remaining capacity, mAh signed
  reg  [15:0] rep_q;        // Reported capacity after hold
  reg  [31:0] acc_q;        // Fractional charge in mA samples
  reg         init_q;       // Initial low charge flag
  reg         final_q;      // Final low charge flag
  reg         dsg_q;        // Discharge in progress
  reg  [2:0]  sts_q;        // Sticky interrupt status
  reg  [2:0]  mask_q;       // Interrupt mask
  reg         aw_have_q;    // Write address held
  reg         w_have_q;     // Write data held
  reg  [7:0]  awaddr_q;     // Held write address
  reg  [31:0] wdata_q;      // Held write data
  reg  [3:0]  wstrb_q;      // Held byte strobes

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  reg  [15:0] cap_d;
  reg  [15:0] rep_d;
  reg  [31:0] acc_d;
  reg         init_d;
  reg         final_d;
  reg         dsg_d;
  reg         upd;
  reg  [7:0]  fac;
  reg  [25:0] chg;
  wire [16:0] cur;
  wire [25:0] prod;
  wire [31:0] acc_sum;
  wire        wr_go;
  wire        wr_hit;

  // Net sense current across the resistor, positive is charge
  assign cur     = $signed({i_sense_input_positive[15], i_sense_input_positive})
                 - $signed({i_sense_input_negative[15], i_sense_input_negative});
  assign prod    = $signed(cur) * $signed({1'b0, fac});
  assign acc_sum = acc_q + {{6{chg[25]}}, chg};
  assign wr_go   = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit  = wr_go && (awaddr_q == `ADDR_CAPACITY);

  // Byte lane merge for partial writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // Byte lane merge for half word registers, upper lanes ignored
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    begin
      merge16 = old;
      // Low byte lane
      if (strb[0]) begin
        merge16[7:0] = nw[7:0];
      end
      // High byte lane
      if (strb[1]) begin
        merge16[15:8] = nw[15:8];
      end
    end
  endfunction

  // Next capacity, reported value and flags
  always @* begin
    fac = eff_q[ctrl_q[`CTRL_EFF_HI:`CTRL_EFF_LO]*8 +: 8];
    // Charge is derated, discharge counts in full
    if ($signed(cur) > 0) begin
      chg = $signed(prod) >>> `EFF_SHIFT;
    end else begin
      chg = {{9{cur[16]}}, cur};
    end
    cap_d   = cap_q;
    acc_d   = acc_q;
    dsg_d   = dsg_q;
    upd     = 1'b0;
    // Software load of capacity restarts the fraction
    if (wr_hit) begin
      cap_d = merge16(cap_q, wdata_q, wstrb_q);
      acc_d = 32'h00000000;
      upd   = 1'b1;
    end else if (i_sense_valid) begin
      upd   = 1'b1;
      // Whole mAh steps leave the accumulator
      if ($signed(acc_sum) >= $signed(`SAMPLES_PER_MAH)) begin
        acc_d = acc_sum - `SAMPLES_PER_MAH;
        cap_d = cap_q + 16'h0001;
      end else if ($signed(acc_sum) <= -$signed(`SAMPLES_PER_MAH)) begin
        acc_d = acc_sum + `SAMPLES_PER_MAH;
        cap_d = cap_q - 16'h0001;
      end else begin
        acc_d = acc_sum;
      end
      // Small currents are noise, not discharge
      dsg_d = $signed({cur[16], cur}) < -$signed({2'b00, dsg_thr_q});
    end
    init_d  = init_q;
    final_d = final_q;
    rep_d   = rep_q;
    if (upd) begin
      // Initial flag with hysteresis
      if ($signed(cap_d) < $signed(init_set_q)) begin
        init_d = 1'b1;
      end else if ($signed(cap_d) > $signed(init_clr_q)) begin
        init_d = 1'b0;
      end
      // Final flag; minus one level never sets it
      if (final_set_q != `FINAL_DISABLED &&
          $signed(cap_d) < $signed(final_set_q)) begin
        final_d = 1'b1;
      end else if (final_q && $signed(cap_d) > $signed(final_clr_q)) begin
        final_d = 1'b0;
      end
      // Hold reported value while discharging until it falls
      if (ctrl_q[`CTRL_HOLD_BIT] && dsg_d &&
          $signed(cap_d) >= $signed(rep_q)) begin
        rep_d = rep_q;
      end else begin
        rep_d = cap_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers and datapath state
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_q      <= `RST_CTRL;
      init_set_q  <= `RST_INIT_SET;
      init_clr_q  <= `RST_INIT_CLR;
      final_set_q <= `RST_FINAL_SET;
      final_clr_q <= `RST_FINAL_CLR;
      dsg_thr_q   <= `RST_DSG_THR;
      eff_q       <= `RST_EFF;
      cap_q       <= `RST_CAPACITY;
      rep_q       <= `RST_CAPACITY;
      acc_q       <= 32'h00000000;
      init_q      <= 1'b0;
      final_q     <= 1'b0;
      dsg_q       <= 1'b0;
      sts_q       <= 3'h0;
      mask_q      <= 3'h0;
    end else begin
      cap_q   <= cap_d;
      rep_q   <= rep_d;
      acc_q   <= acc_d;
      init_q  <= init_d;
      final_q <= final_d;
      dsg_q   <= dsg_d;
      // Sticky events: set wins over write one to clear
      sts_q <= (sts_q & ~((wr_go && awaddr_q == `ADDR_INT_STS) ?
                          wdata_q[`EV_W-1:0] & {3{wstrb_q[0]}} : 3'h0))
             | {dsg_d & ~dsg_q, final_d & ~final_q, init_d & ~init_q};
      // Configuration writes
      if (wr_go) begin
        if (awaddr_q == `ADDR_CTRL) begin
          ctrl_q <= wstrb_q[0] ? wdata_q[`CTRL_EFF_HI:0] : ctrl_q;
        end else if (awaddr_q == `ADDR_INIT_SET) begin
          init_set_q <= merge16(init_set_q, wdata_q, wstrb_q);
        end else if (awaddr_q == `ADDR_INIT_CLR) begin
          init_clr_q <= merge16(init_clr_q, wdata_q, wstrb_q);
        end else if (awaddr_q == `ADDR_FINAL_SET) begin
          final_set_q <= merge16(final_set_q, wdata_q, wstrb_q);
        end else if (awaddr_q == `ADDR_FINAL_CLR) begin
          final_clr_q <= merge16(final_clr_q, wdata_q, wstrb_q);
        end else if (awaddr_q == `ADDR_DSG_THR) begin
          dsg_thr_q <= merge16(dsg_thr_q, wdata_q, wstrb_q);
        end else if (awaddr_q == `ADDR_EFF) begin
          eff_q <= merge(eff_q, wdata_q, wstrb_q);
        end else if (awaddr_q == `ADDR_INT_MASK) begin
          mask_q <= wstrb_q[0] ? wdata_q[`EV_W-1:0] : mask_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;

  // Capture address and data in either order, answer once both held
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Read only and unmapped words refuse writes
        if (awaddr_q <= `ADDR_CAPACITY || awaddr_q == `ADDR_INT_STS ||
            awaddr_q == `ADDR_INT_MASK) begin
          s_axi_bresp <= (awaddr_q[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Reads have no side effect
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      if (s_axi_araddr == `ADDR_CTRL) begin
        s_axi_rdata <= {29'h0, ctrl_q};
      end else if (s_axi_araddr == `ADDR_INIT_SET) begin
        s_axi_rdata <= {16'h0, init_set_q};
      end else if (s_axi_araddr == `ADDR_INIT_CLR) begin
        s_axi_rdata <= {16'h0, init_clr_q};
      end else if (s_axi_araddr == `ADDR_FINAL_SET) begin
        s_axi_rdata <= {16'h0, final_set_q};
      end else if (s_axi_araddr == `ADDR_FINAL_CLR) begin
        s_axi_rdata <= {16'h0, final_clr_q};
      end else if (s_axi_araddr == `ADDR_DSG_THR) begin
        s_axi_rdata <= {16'h0, dsg_thr_q};
      end else if (s_axi_araddr == `ADDR_EFF) begin
        s_axi_rdata <= eff_q;
      end else if (s_axi_araddr == `ADDR_CAPACITY) begin
        s_axi_rdata <= {16'h0, cap_q};
      end else if (s_axi_araddr == `ADDR_FLAGS) begin
        s_axi_rdata <= {29'h0, dsg_q, final_q, init_q};
      end else if (s_axi_araddr == `ADDR_REPORTED) begin
        s_axi_rdata <= {16'h0, rep_q};
      end else if (s_axi_araddr == `ADDR_INT_STS) begin
        s_axi_rdata <= {29'h0, sts_q};
      end else if (s_axi_araddr == `ADDR_INT_MASK) begin
        s_axi_rdata <= {29'h0, mask_q};
      end else begin
        s_axi_rresp <= `RESP_SLVERR;  // Unmapped
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_initial_low_charge_flag = init_q;
  assign o_final_low_charge_flag   = final_q;
  assign o_reported_capacity       = rep_q;
  assign o_irq                     = |(sts_q & mask_q);

endmodule

// file: tb/charge_level_warning_flags_assertions.sv
/*
 Port checker for the charge level warning block.
 Assumes it is bound to the block's top and sees only its ports.
*/
`timescale 1ns/1ps
module level_warning_checker (
  // Clock and reset
  input logic        i_sys_clk, i_rst,
  // Bus and sense handshakes
  input logic        i_sense_valid, s_axi_awready, s_axi_wready,
  input logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input logic        s_axi_arready, s_axi_rvalid, s_axi_rready,
  input logic [1:0]  s_axi_bresp,
  input logic [31:0] s_axi_rdata,
  // Status outputs
  input logic        o_initial_low_charge_flag, o_final_low_charge_flag, o_irq,
  input logic [15:0] o_reported_capacity
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_irq_rst; disable iff (1'b0) i_rst |=> !o_irq; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_done: assert property (p_r_done) else $error("read data not retired");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("write response not retired");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("write taken during response");
  // Flags and reported value move only on a sample or a register write
  property p_state_cause;
    !$stable({o_initial_low_charge_flag, o_final_low_charge_flag, o_reported_capacity})
      |-> $past(i_sense_valid) || $rose(s_axi_bvalid);
  endproperty
  a_state_cause: assert property (p_state_cause) else $error("state moved alone");
  property p_irq_cause; !$stable(o_irq) |-> $past(i_sense_valid) || $rose(s_axi_bvalid);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq moved alone");
endmodule
bind charge_level_warning_flags level_warning_checker level_warning_checker_i (.*);

// file: tb/sense_resistor_model.sv
/*
 Series sense resistor as seen through the sampling converter.
 Assumes the bench fires one sample per pulse of i_fire.
*/
`timescale 1ns/1ps
module sense_resistor_model (
  // Commanded sample
  input  logic               i_fire,
  input  logic signed [15:0] i_current,
  // Sample towards the block
  output logic [15:0]        o_pos,
  output logic [15:0]        o_neg,
  output logic               o_valid
);
  localparam logic [15:0] BIAS = 16'h0100; // Common mode on both sides
  // Net current is pos minus neg; idle lines show inverted data
  assign o_valid = i_fire;
  assign o_pos   = i_fire ? BIAS + i_current : ~(BIAS + i_current);
  assign o_neg   = i_fire ? BIAS : ~BIAS;
endmodule

// file: tb/testbench.sv
/*
 Self-checking bench for the charge level warning block.
 Assumes the sense model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic i_sys_clk = 0, i_rst = 1, fire = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic signed [15:0] cur = 16'sh0000;  // Commanded current, mA
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h00000000, d;
  logic [1:0]  r;
  wire awr, wr_rdy, bv, arr, rv, f_ini, f_fin, irq, sv;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [15:0] rep, sp, sn;
  int num_errors = 0, check_count = 0, cyc = 0;
  always #25 i_sys_clk = ~i_sys_clk;
  charge_level_warning_flags charge_level_warning_flags_i (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_sense_input_positive(sp), .i_sense_input_negative(sn),
    .i_sense_valid(sv), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .o_initial_low_charge_flag(f_ini),
    .o_final_low_charge_flag(f_fin), .o_reported_capacity(rep), .o_irq(irq));
  sense_resistor_model sense_resistor_model_i (.i_fire(fire), .i_current(cur),
    .o_pos(sp), .o_neg(sn), .o_valid(sv));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      final_report;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus write: both halves offered, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0,
                    input int lag = 0);
    logic ad, wn, ah, wh;
    ad = 0;
    wn = 0;
    awa <= a; wd <= v; awv <= 1; wv <= 1;
    while (!(ad && wn)) begin
      @(negedge i_sys_clk); ah = awv && awr; wh = wv && wr_rdy;
      @(posedge i_sys_clk); if (ah) awv <= 0; if (wh) wv <= 0;
      ad = ad | ah;
      wn = wn | wh;
    end
    repeat (lag) @(posedge i_sys_clk);
    bre <= 1;
    do begin @(negedge i_sys_clk); ah = bv; r = br; @(posedge i_sys_clk); end while (!ah);
    bre <= 0;
    chk("bresp", er, r);
  endtask
  // Bus read: address, then data with rready
  task automatic rd(input logic [7:0] a);
    logic h;
    ara <= a; arv <= 1;
    do begin @(negedge i_sys_clk); h = arr; @(posedge i_sys_clk); end while (!h);
    arv <= 0;
    @(posedge i_sys_clk);
    rre <= 1;
    do begin @(negedge i_sys_clk); h = rv; d = rdat; r = rr; @(posedge i_sys_clk); end
      while (!h);
    rre <= 0;
  endtask
  // One sense sample, n times
  task automatic smp(input logic signed [15:0] c, input int n = 1);
    repeat (n) begin
      fire <= 1; cur <= c; @(posedge i_sys_clk); fire <= 0; @(posedge i_sys_clk);
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] ad [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
      8'h20, 8'h28, 8'h2c};
    logic [31:0] ev [11] = '{32'h0, 32'h64, 32'h96, 32'h32, 32'h64, 32'h3c,
      32'hffffffff, 32'h3e8, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 11; i++) begin
      rd(ad[i]);
      chk("reset value", ev[i], d);
      chk("read resp", 2'h0, r);
    end
    chk("reported at reset", 32'h3e8, rep);
    rd(8'h40);
    chk("unmapped resp", 2'h2, r);
    chk("unmapped data", 32'h0, d);
    wr(8'h20, 32'h7, 2'h2);
    $display("test regs done");
  endtask
  task automatic t_init;
    wr(8'h18, 32'h80808080);
    wr(8'h1c, 32'h65);
    smp(16'shf1f0); // Minus 3600 mA for one sample
    chk("cap 100", 32'h64, rep);
    chk("init at 100", 1'b0, f_ini);
    smp(16'shf1f0);
    chk("init at 99", 1'b1, f_ini);
    wr(8'h1c, 32'h95);
    smp(16'sh1c20); // Plus 7200 mA at half efficiency
    chk("init at 150", 1'b1, f_ini);
    smp(16'sh1c20);
    chk("init at 151", 1'b0, f_ini);
    $display("test initial flag done");
  endtask
  task automatic t_final;
    wr(8'h1c, 32'h33);
    smp(16'shf1f0);
    chk("final at 50", 1'b0, f_fin);
    smp(16'shf1f0);
    chk("final at 49", 1'b1, f_fin);
    wr(8'h1c, 32'h64);
    chk("final at 100", 1'b1, f_fin);
    smp(16'sh1c20);
    chk("final at 101", 1'b0, f_fin);
    wr(8'h0c, 32'hffff);
    wr(8'h1c, 32'h0);
    smp(16'shf1f0, 2);
    chk("cap minus 2", 32'hfffe, rep);
    chk("final disabled", 1'b0, f_fin);
    $display("test final flag done");
  endtask
  task automatic t_eff;
    for (int k = 0; k < 4; k++) begin
      wr(8'h18, 32'h40404040 ^ (32'hc0 << (8 * k)));
      wr(8'h00, 32'(k << 1));
      wr(8'h1c, 32'h12c);
      smp(16'sh1c20);
      chk("scaled charge", 32'h12d, rep);
    end
    $display("test efficiency done");
  endtask
  task automatic t_hold;
    wr(8'h00, 32'h0);
    wr(8'h1c, 32'h258);
    smp(16'sh0000);
    chk("reported 600", 32'h258, rep);
    wr(8'h00, 32'h1);
    smp(16'shffc3); // Minus 61 mA
    wr(8'h1c, 32'h2bc);
    chk("held", 32'h258, rep);
    rd(8'h20);
    chk("discharging", 1'b1, d[2]);
    smp(16'shffc4); // Minus 60 mA
    chk("released", 32'h2bc, rep);
    rd(8'h20);
    chk("not discharging", 1'b0, d[2]);
    $display("test hold done");
  endtask
  task automatic t_irq;
    wr(8'h28, 32'h7);
    wr(8'h2c, 32'h0);
    wr(8'h1c, 32'h64);
    smp(16'shf1f0);
    chk("irq masked", 1'b0, irq);
    rd(8'h28);
    chk("status", 32'h5, d);
    wr(8'h2c, 32'h1, 2'h0, 2);
    chk("irq unmasked", 1'b1, irq);
    wr(8'h28, 32'h1);
    chk("irq cleared", 1'b0, irq);
    rd(8'h28);
    chk("status after clear", 32'h4, d);
    repeat (2) begin
      rd(8'h20);
      chk("flags word", 32'h5, d);
    end
    $display("test interrupt done");
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 0;
    @(posedge i_sys_clk);
    t_regs;
    t_init;
    t_final;
    t_eff;
    t_hold;
    t_irq;
    final_report;
  end
endmodule
